// ==== src/pbs_pkg.sv ====
package pbs_pkg;
  // Bit positions in the shared sustained tri-state control group
  localparam int CTL_FRAME = 0;
  localparam int CTL_IRDY = 1;
  localparam int CTL_TRDY = 2;
  localparam int CTL_STOP = 3;
  localparam int CTL_DEVSEL = 4;
  localparam int CTL_W = 5;
  // Bus commands
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  // Decode windows of the device end and of the host end
  localparam logic [31:0] DEV_BASE = 32'h0000_1000;
  localparam logic [31:0] DEV_MASK = 32'hFFFF_FFF0;
  localparam logic [31:0] HOST_BASE = 32'h8000_0000;
  localparam logic [31:0] HOST_MASK = 32'hFFFF_FFF0;
  // Identity word at configuration index 0; the value is arbitrary
  localparam logic [31:0] ID_WORD = 32'h1234_5678;
  // Timing counts in bus clocks
  localparam logic [2:0] MABORT_CLKS = 3'h5;
  localparam logic [2:0] SUB_CLKS = 3'h3;
  // Reset and idle values
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [1:0] IDX_RST = 2'h0;
  localparam logic [2:0] CNT_RST = 3'h0;
  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [3:0] BE_RST = 4'hF;
  // Answer codes of an initiator transfer
  localparam logic [1:0] RSP_OK = 2'h0;
  localparam logic [1:0] RSP_STOP = 2'h1;
  localparam logic [1:0] RSP_ABORT = 2'h2;
  // Target and initiator states, Gray along the usual path
  typedef enum logic [2:0] {T_IDLE = 3'h0, T_WAIT = 3'h1, T_DATA = 3'h3, T_STOP = 3'h2, T_TURN = 3'h6} pbs_tgt_e;
  typedef enum logic [2:0] {M_IDLE = 3'h0, M_REQ = 3'h1, M_ADDR = 3'h3, M_DATA = 3'h2, M_TURN = 3'h6} pbs_mst_e;
endpackage

// ==== src/pbs_bus_if.sv ====
`timescale 1ns/1ps
interface pbs_bus_if;
  // Device end drivers
  logic [31:0] devAdO;
  logic devAdOe;
  logic [3:0] devCbeO;
  logic devCbeOe;
  logic devParO;
  logic devParOe;
  logic [4:0] devCtlO;
  logic [4:0] devCtlOe;
  logic busHoldRequestN;
  // Host end drivers
  logic [31:0] hostAdO;
  logic hostAdOe;
  logic [3:0] hostCbeO;
  logic hostCbeOe;
  logic hostParO;
  logic hostParOe;
  logic [4:0] hostCtlO;
  logic [4:0] hostCtlOe;
  logic idsel;
  logic busHoldGrantN;
  logic hostSerrOe;
  // Resolved wire levels
  logic [31:0] ad;
  logic [3:0] cbeN;
  logic par;
  logic [4:0] ctlN;
  logic serrN;
  // Floating data lines read as zero; controls rest high on the pull-up
  assign ad = ({32{devAdOe}} & devAdO) | ({32{hostAdOe}} & hostAdO);
  assign cbeN = ({4{devCbeOe}} & devCbeO) | ({4{hostCbeOe}} & hostCbeO);
  assign par = (devParOe & devParO) | (hostParOe & hostParO);
  assign ctlN = (devCtlOe & devCtlO) | (hostCtlOe & hostCtlO) | ~(devCtlOe | hostCtlOe);
  assign serrN = ~hostSerrOe;
  modport dev (
    output devAdO, devAdOe, devCbeO, devCbeOe, devParO, devParOe, devCtlO, devCtlOe, busHoldRequestN,
    input ad, cbeN, par, ctlN, serrN, idsel, busHoldGrantN
  );
  modport host (
    output hostAdO, hostAdOe, hostCbeO, hostCbeOe, hostParO, hostParOe, hostCtlO, hostCtlOe, idsel,
    output busHoldGrantN, hostSerrOe,
    input ad, cbeN, par, ctlN, busHoldRequestN
  );
endinterface

// ==== src/pbs_device_end.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Names ending N are asserted low
// - Drive owned control high before release
// - Start driving only after one idle clock
// - Everything sampled on rising bus clock
// - Address with frame, data in following clocks
// - Command with frame, then byte enables
// - Frame negated before the last transfer
// - Target ready only when it can transfer
// - Initiator ready only when it can transfer
// - Stop from target ends the transaction
// - Configuration answered only with select high
// - Claim by positive or subtractive decode
// - Parity even over data, command, parity
// - Any agent may pulse system error; here only the host end drives it
// - Sampled system error raises enabled NMI
// - Hold request asserted while bus needed
// - Passive release: request high one clock
// - Arbiter grants through hold grant
module pbs_device_end (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Shared bus
  pbs_bus_if.dev bus,
  // Target options and error report
  input wire logic subtractiveEn,
  input wire logic serrNmiEn,
  input wire logic nmiClear,
  output logic nmi,
  // Initiator request
  input wire logic reqValid,
  input wire logic [3:0] reqCmd,
  input wire logic [31:0] reqAddr,
  input wire logic [31:0] reqData,
  input wire logic [3:0] reqBeN,
  input wire logic passiveRelease,
  output logic reqReady,
  // Initiator answer
  output logic rspValid,
  output logic [1:0] rspStatus,
  output logic [31:0] rspData
);
  // Sampled bus levels; the bus runs on this clock, so no synchroniser
  logic frameN;
  logic irdyN;
  logic trdyN;
  logic stopN;
  logic devselN;
  assign frameN = bus.ctlN[pbs_pkg::CTL_FRAME];
  assign irdyN = bus.ctlN[pbs_pkg::CTL_IRDY];
  assign trdyN = bus.ctlN[pbs_pkg::CTL_TRDY];
  assign stopN = bus.ctlN[pbs_pkg::CTL_STOP];
  assign devselN = bus.ctlN[pbs_pkg::CTL_DEVSEL];

  // Command decoders
  function automatic logic isCfg(input logic [3:0] c);
    isCfg = (c == pbs_pkg::CMD_CFG_RD) || (c == pbs_pkg::CMD_CFG_WR);
  endfunction
  function automatic logic isIoMem(input logic [3:0] c);
    isIoMem = (c == pbs_pkg::CMD_IO_RD) || (c == pbs_pkg::CMD_IO_WR) || (c == pbs_pkg::CMD_MEM_RD) ||
              (c == pbs_pkg::CMD_MEM_WR);
  endfunction

  // Bus history: address phase is the first clock of frame asserted
  logic frameQ_q;
  logic idleQ_q;
  logic addrPhase;
  logic busIdle2;
  assign addrPhase = !frameN && frameQ_q;
  assign busIdle2 = frameN && irdyN && idleQ_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      frameQ_q <= 1'b1;
      idleQ_q <= 1'b0;
    end
    else
    begin
      frameQ_q <= frameN;
      idleQ_q <= frameN && irdyN;
    end
  end

  // Target decode; selections come from the bus in the address phase
  pbs_pkg::pbs_tgt_e tState_q;
  pbs_pkg::pbs_tgt_e tState_d;
  logic [2:0] tCnt_q;
  logic [2:0] tCnt_d;
  logic [1:0] tIdx_q;
  logic tWrite_q;
  logic tCfg_q;
  logic [1:0] tSelIdx;
  logic tSelWr;
  logic tSelCfg;
  logic posHit;
  logic subCand;
  logic tXfer;
  logic tRdStart;
  logic [31:0] rdWord;
  logic [31:0] beMask;
  logic [31:0] store_q [4];
  assign tSelIdx = (tState_q == pbs_pkg::T_IDLE) ? bus.ad[3:2] : tIdx_q;
  assign tSelWr = (tState_q == pbs_pkg::T_IDLE) ? bus.cbeN[0] : tWrite_q;
  assign tSelCfg = (tState_q == pbs_pkg::T_IDLE) ? isCfg(bus.cbeN) : tCfg_q;
  assign posHit = (isIoMem(bus.cbeN) && ((bus.ad & pbs_pkg::DEV_MASK) == pbs_pkg::DEV_BASE)) ||
                  (isCfg(bus.cbeN) && bus.idsel);
  assign subCand = subtractiveEn && isIoMem(bus.cbeN) && !posHit;
  assign tXfer = (tState_q == pbs_pkg::T_DATA) && !irdyN;
  assign tRdStart = (tState_d == pbs_pkg::T_DATA) && (tState_q != pbs_pkg::T_DATA) && !tSelWr;
  assign rdWord = (tSelCfg && (tSelIdx == pbs_pkg::IDX_RST)) ? pbs_pkg::ID_WORD : store_q[tSelIdx];

  // Byte lane mask from the active-low byte enables
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++)
    begin : g_lane
      assign beMask[gb*8 +: 8] = {8{!bus.cbeN[gb]}};
    end
  endgenerate

  // Target sequence: claim, one transfer, disconnect on a burst, turnaround
  always_comb
  begin
    tState_d = tState_q;
    tCnt_d = tCnt_q;
    case (tState_q)
      pbs_pkg::T_IDLE:
      begin
        tCnt_d = pbs_pkg::CNT_RST;
        if (addrPhase && posHit)
          tState_d = pbs_pkg::T_DATA;
        else if (addrPhase && subCand)
          tState_d = pbs_pkg::T_WAIT;
      end
      pbs_pkg::T_WAIT:
      begin
        // Another agent claimed, or the initiator gave up
        if (!devselN || (frameN && irdyN))
          tState_d = pbs_pkg::T_IDLE;
        else if (tCnt_q == pbs_pkg::SUB_CLKS)
          tState_d = pbs_pkg::T_DATA;
        else
          tCnt_d = tCnt_q + pbs_pkg::CNT_ONE;
      end
      pbs_pkg::T_DATA:
        if (tXfer)
          tState_d = frameN ? pbs_pkg::T_TURN : pbs_pkg::T_STOP;
      pbs_pkg::T_STOP:
        if (frameN)
          tState_d = pbs_pkg::T_TURN;
      pbs_pkg::T_TURN:
        tState_d = pbs_pkg::T_IDLE;
      default:
        tState_d = pbs_pkg::T_IDLE;
    endcase
  end

  // Target control drivers, all from next state so they leave flops
  logic [2:0] tCtlO_q;
  logic [2:0] tCtlOe_q;
  logic tOwn;
  assign tOwn = (tState_d != pbs_pkg::T_IDLE) && (tState_d != pbs_pkg::T_WAIT);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tState_q <= pbs_pkg::T_IDLE;
      tCnt_q <= pbs_pkg::CNT_RST;
      tIdx_q <= pbs_pkg::IDX_RST;
      tWrite_q <= 1'b0;
      tCfg_q <= 1'b0;
      tCtlO_q <= 3'h7;
      tCtlOe_q <= 3'h0;
    end
    else
    begin
      tState_q <= tState_d;
      tCnt_q <= tCnt_d;
      tIdx_q <= tSelIdx;
      tWrite_q <= tSelWr;
      tCfg_q <= tSelCfg;
      tCtlO_q <= {(tState_d != pbs_pkg::T_DATA) && (tState_d != pbs_pkg::T_STOP), tState_d != pbs_pkg::T_STOP,
                  tState_d != pbs_pkg::T_DATA};
      tCtlOe_q <= {3{tOwn}};
    end
  end

  // Word store; only the enabled byte lanes change on a write transfer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 4; i++)
        store_q[i] <= pbs_pkg::WORD_RST;
    end
    else if (tXfer && tWrite_q)
      store_q[tIdx_q] <= (store_q[tIdx_q] & ~beMask) | (bus.ad & beMask);
  end

  // Initiator sequence
  pbs_pkg::pbs_mst_e mState_q;
  pbs_pkg::pbs_mst_e mState_d;
  logic [2:0] mCnt_q;
  logic [3:0] mCmd_q;
  logic [3:0] mBeN_q;
  logic [31:0] mAddr_q;
  logic [31:0] mData_q;
  logic holdN_q;
  logic relQ_q;
  logic relNow;
  logic granted;
  logic mEnd;
  assign granted = !bus.busHoldGrantN && !holdN_q && busIdle2;
  assign mEnd = (mState_q == pbs_pkg::M_DATA) &&
                (!trdyN || !stopN || ((mCnt_q == pbs_pkg::MABORT_CLKS) && devselN));
  assign relNow = passiveRelease && !holdN_q && !relQ_q;
  always_comb
  begin
    mState_d = mState_q;
    case (mState_q)
      pbs_pkg::M_IDLE:
        if (reqValid)
          mState_d = pbs_pkg::M_REQ;
      pbs_pkg::M_REQ:
        if (granted)
          mState_d = pbs_pkg::M_ADDR;
      pbs_pkg::M_ADDR:
        mState_d = pbs_pkg::M_DATA;
      pbs_pkg::M_DATA:
        if (mEnd)
          mState_d = pbs_pkg::M_TURN;
      pbs_pkg::M_TURN:
        mState_d = pbs_pkg::M_IDLE;
      default:
        mState_d = pbs_pkg::M_IDLE;
    endcase
  end

  // Initiator registers, hold request and answer
  logic [1:0] mCtlO_q;
  logic [1:0] mCtlOe_q;
  logic reqReady_q;
  logic rspValid_q;
  logic [1:0] rspStatus_q;
  logic [31:0] rspData_q;
  logic mNeed;
  assign mNeed = (mState_d == pbs_pkg::M_REQ) || (mState_d == pbs_pkg::M_ADDR) || (mState_d == pbs_pkg::M_DATA);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mState_q <= pbs_pkg::M_IDLE;
      mCnt_q <= pbs_pkg::CNT_ONE;
      mCmd_q <= pbs_pkg::CMD_MEM_RD;
      mBeN_q <= pbs_pkg::BE_RST;
      mAddr_q <= pbs_pkg::WORD_RST;
      mData_q <= pbs_pkg::WORD_RST;
      holdN_q <= 1'b1;
      relQ_q <= 1'b0;
      mCtlO_q <= 2'h3;
      mCtlOe_q <= 2'h0;
      reqReady_q <= 1'b0;
      rspValid_q <= 1'b0;
      rspStatus_q <= pbs_pkg::RSP_OK;
      rspData_q <= pbs_pkg::WORD_RST;
    end
    else
    begin
      mState_q <= mState_d;
      mCnt_q <= (mState_q == pbs_pkg::M_DATA) ? mCnt_q + pbs_pkg::CNT_ONE : pbs_pkg::CNT_ONE;
      if ((mState_q == pbs_pkg::M_IDLE) && reqValid)
      begin
        mCmd_q <= reqCmd;
        mBeN_q <= reqBeN;
        mAddr_q <= reqAddr;
        mData_q <= reqData;
      end
      holdN_q <= !mNeed || relNow;
      relQ_q <= relNow;
      mCtlO_q <= {mState_d != pbs_pkg::M_DATA, mState_d != pbs_pkg::M_ADDR};
      mCtlOe_q <= {2{mNeed && (mState_d != pbs_pkg::M_REQ) || (mState_d == pbs_pkg::M_TURN)}};
      reqReady_q <= mState_d == pbs_pkg::M_IDLE;
      rspValid_q <= mEnd;
      if (mEnd)
      begin
        rspStatus_q <= !trdyN ? pbs_pkg::RSP_OK : (!stopN ? pbs_pkg::RSP_STOP : pbs_pkg::RSP_ABORT);
        if (!trdyN && !mCmd_q[0])
          rspData_q <= bus.ad;
      end
    end
  end

  // Shared address/data drivers of both roles, then parity one clock later
  logic [31:0] adO_q;
  logic adOe_q;
  logic [3:0] cbeO_q;
  logic cbeOe_q;
  logic parO_q;
  logic parOe_q;
  logic nmi_q;
  logic mAddrNow;
  logic mDataNow;
  assign mAddrNow = mState_d == pbs_pkg::M_ADDR;
  assign mDataNow = (mState_d == pbs_pkg::M_DATA) && mCmd_q[0];
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      adO_q <= pbs_pkg::WORD_RST;
      adOe_q <= 1'b0;
      cbeO_q <= pbs_pkg::BE_RST;
      cbeOe_q <= 1'b0;
      parO_q <= 1'b0;
      parOe_q <= 1'b0;
      nmi_q <= 1'b0;
    end
    else
    begin
      adO_q <= mAddrNow ? mAddr_q : (mDataNow ? mData_q : (tRdStart ? rdWord : adO_q));
      adOe_q <= mAddrNow || mDataNow || ((tState_d == pbs_pkg::T_DATA) && !tSelWr);
      cbeO_q <= mAddrNow ? mCmd_q : mBeN_q;
      cbeOe_q <= mAddrNow || (mState_d == pbs_pkg::M_DATA);
      parO_q <= ^{adO_q, bus.cbeN};
      parOe_q <= adOe_q;
      // Set beats clear so an error in the clearing clock is kept
      nmi_q <= (serrNmiEn && !bus.serrN) || (nmi_q && !nmiClear);
    end
  end

  // Port drive
  assign bus.devCtlO = {tCtlO_q, mCtlO_q};
  assign bus.devCtlOe = {tCtlOe_q, mCtlOe_q};
  assign bus.devAdO = adO_q;
  assign bus.devAdOe = adOe_q;
  assign bus.devCbeO = cbeO_q;
  assign bus.devCbeOe = cbeOe_q;
  assign bus.devParO = parO_q;
  assign bus.devParOe = parOe_q;
  assign bus.busHoldRequestN = holdN_q;
  assign nmi = nmi_q;
  assign reqReady = reqReady_q;
  assign rspValid = rspValid_q;
  assign rspStatus = rspStatus_q;
  assign rspData = rspData_q;
endmodule // pbs_device_end

// ==== src/pbs_host_end.sv ====
`timescale 1ns/1ps
module pbs_host_end (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Shared bus
  pbs_bus_if.host bus,
  // Error report
  input wire logic serrPulse,
  // Initiator request
  input wire logic reqValid,
  input wire logic [3:0] reqCmd,
  input wire logic [31:0] reqAddr,
  input wire logic [31:0] reqData,
  input wire logic [3:0] reqBeN,
  output logic reqReady,
  // Initiator answer
  output logic rspValid,
  output logic [1:0] rspStatus,
  output logic [31:0] rspData
);
  // Sampled bus levels
  logic frameN;
  logic irdyN;
  logic trdyN;
  logic stopN;
  logic devselN;
  logic frameQ_q;
  logic idleQ_q;
  logic addrPhase;
  logic busIdle2;
  assign frameN = bus.ctlN[pbs_pkg::CTL_FRAME];
  assign irdyN = bus.ctlN[pbs_pkg::CTL_IRDY];
  assign trdyN = bus.ctlN[pbs_pkg::CTL_TRDY];
  assign stopN = bus.ctlN[pbs_pkg::CTL_STOP];
  assign devselN = bus.ctlN[pbs_pkg::CTL_DEVSEL];
  assign addrPhase = !frameN && frameQ_q;
  assign busIdle2 = frameN && irdyN && idleQ_q;

  // Initiator and arbiter; a waiting host yields to the device request
  pbs_pkg::pbs_mst_e hState_q;
  pbs_pkg::pbs_mst_e hState_d;
  logic [2:0] hCnt_q;
  logic [3:0] hCmd_q;
  logic [3:0] hBeN_q;
  logic [31:0] hAddr_q;
  logic [31:0] hData_q;
  logic grantN_q;
  logic hGo;
  logic hEnd;
  logic hNeed;
  assign hGo = grantN_q && bus.busHoldRequestN && busIdle2;
  assign hEnd = (hState_q == pbs_pkg::M_DATA) &&
                (!trdyN || !stopN || ((hCnt_q == pbs_pkg::MABORT_CLKS) && devselN));
  assign hNeed = (hState_d == pbs_pkg::M_ADDR) || (hState_d == pbs_pkg::M_DATA) || (hState_d == pbs_pkg::M_TURN);
  always_comb
  begin
    hState_d = hState_q;
    case (hState_q)
      pbs_pkg::M_IDLE:
        if (reqValid)
          hState_d = pbs_pkg::M_REQ;
      pbs_pkg::M_REQ:
        if (hGo)
          hState_d = pbs_pkg::M_ADDR;
      pbs_pkg::M_ADDR:
        hState_d = pbs_pkg::M_DATA;
      pbs_pkg::M_DATA:
        if (hEnd)
          hState_d = pbs_pkg::M_TURN;
      pbs_pkg::M_TURN:
        hState_d = pbs_pkg::M_IDLE;
      default:
        hState_d = pbs_pkg::M_IDLE;
    endcase
  end

  // Target for device-initiated cycles: one word, one transfer each
  pbs_pkg::pbs_tgt_e tState_q;
  pbs_pkg::pbs_tgt_e tState_d;
  logic tWrite_q;
  logic [31:0] word_q;
  logic tHit;
  logic tXfer;
  assign tHit = addrPhase && (hState_q != pbs_pkg::M_ADDR) && ((bus.ad & pbs_pkg::HOST_MASK) == pbs_pkg::HOST_BASE) &&
                ((bus.cbeN == pbs_pkg::CMD_MEM_RD) || (bus.cbeN == pbs_pkg::CMD_MEM_WR));
  assign tXfer = (tState_q == pbs_pkg::T_DATA) && !irdyN;
  always_comb
  begin
    tState_d = tState_q;
    case (tState_q)
      pbs_pkg::T_IDLE:
        if (tHit)
          tState_d = pbs_pkg::T_DATA;
      pbs_pkg::T_DATA:
        if (tXfer)
          tState_d = frameN ? pbs_pkg::T_TURN : pbs_pkg::T_STOP;
      pbs_pkg::T_STOP:
        if (frameN)
          tState_d = pbs_pkg::T_TURN;
      pbs_pkg::T_TURN:
        tState_d = pbs_pkg::T_IDLE;
      default:
        tState_d = pbs_pkg::T_IDLE;
    endcase
  end

  // All host registers
  logic [4:0] ctlO_q;
  logic [4:0] ctlOe_q;
  logic [31:0] adO_q;
  logic adOe_q;
  logic [3:0] cbeO_q;
  logic cbeOe_q;
  logic parO_q;
  logic parOe_q;
  logic idsel_q;
  logic serrOe_q;
  logic reqReady_q;
  logic rspValid_q;
  logic [1:0] rspStatus_q;
  logic [31:0] rspData_q;
  logic tOwn;
  logic tRd;
  assign tOwn = tState_d != pbs_pkg::T_IDLE;
  assign tRd = (tState_d == pbs_pkg::T_DATA) && !((tState_q == pbs_pkg::T_IDLE) ? bus.cbeN[0] : tWrite_q);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      frameQ_q <= 1'b1;
      idleQ_q <= 1'b0;
      hState_q <= pbs_pkg::M_IDLE;
      hCnt_q <= pbs_pkg::CNT_ONE;
      hCmd_q <= pbs_pkg::CMD_MEM_RD;
      hBeN_q <= pbs_pkg::BE_RST;
      hAddr_q <= pbs_pkg::WORD_RST;
      hData_q <= pbs_pkg::WORD_RST;
      grantN_q <= 1'b1;
      tState_q <= pbs_pkg::T_IDLE;
      tWrite_q <= 1'b0;
      word_q <= pbs_pkg::WORD_RST;
      ctlO_q <= 5'h1F;
      ctlOe_q <= 5'h00;
      adO_q <= pbs_pkg::WORD_RST;
      adOe_q <= 1'b0;
      cbeO_q <= pbs_pkg::BE_RST;
      cbeOe_q <= 1'b0;
      parO_q <= 1'b0;
      parOe_q <= 1'b0;
      idsel_q <= 1'b0;
      serrOe_q <= 1'b0;
      reqReady_q <= 1'b0;
      rspValid_q <= 1'b0;
      rspStatus_q <= pbs_pkg::RSP_OK;
      rspData_q <= pbs_pkg::WORD_RST;
    end
    else
    begin
      frameQ_q <= frameN;
      idleQ_q <= frameN && irdyN;
      hState_q <= hState_d;
      hCnt_q <= (hState_q == pbs_pkg::M_DATA) ? hCnt_q + pbs_pkg::CNT_ONE : pbs_pkg::CNT_ONE;
      if ((hState_q == pbs_pkg::M_IDLE) && reqValid)
      begin
        hCmd_q <= reqCmd;
        hBeN_q <= reqBeN;
        hAddr_q <= reqAddr;
        hData_q <= reqData;
      end
      grantN_q <= !(!bus.busHoldRequestN && !hNeed);
      tState_q <= tState_d;
      tWrite_q <= (tState_q == pbs_pkg::T_IDLE) ? bus.cbeN[0] : tWrite_q;
      if (tXfer && tWrite_q)
        word_q <= bus.ad;
      ctlO_q <= {(tState_d != pbs_pkg::T_DATA) && (tState_d != pbs_pkg::T_STOP), tState_d != pbs_pkg::T_STOP,
                 tState_d != pbs_pkg::T_DATA, hState_d != pbs_pkg::M_DATA, hState_d != pbs_pkg::M_ADDR};
      ctlOe_q <= {{3{tOwn}}, {2{hNeed}}};
      adO_q <= (hState_d == pbs_pkg::M_ADDR) ? hAddr_q : ((hState_d == pbs_pkg::M_DATA) ? hData_q : word_q);
      adOe_q <= (hState_d == pbs_pkg::M_ADDR) || ((hState_d == pbs_pkg::M_DATA) && hCmd_q[0]) || tRd;
      cbeO_q <= (hState_d == pbs_pkg::M_ADDR) ? hCmd_q : hBeN_q;
      cbeOe_q <= (hState_d == pbs_pkg::M_ADDR) || (hState_d == pbs_pkg::M_DATA);
      parO_q <= ^{adO_q, bus.cbeN};
      parOe_q <= adOe_q;
      idsel_q <= (hState_d == pbs_pkg::M_ADDR) && ((hCmd_q == pbs_pkg::CMD_CFG_RD) || (hCmd_q == pbs_pkg::CMD_CFG_WR));
      serrOe_q <= serrPulse;
      reqReady_q <= hState_d == pbs_pkg::M_IDLE;
      rspValid_q <= hEnd;
      if (hEnd)
      begin
        rspStatus_q <= !trdyN ? pbs_pkg::RSP_OK : (!stopN ? pbs_pkg::RSP_STOP : pbs_pkg::RSP_ABORT);
        if (!trdyN && !hCmd_q[0])
          rspData_q <= bus.ad;
      end
    end
  end

  // Port drive
  assign bus.hostCtlO = ctlO_q;
  assign bus.hostCtlOe = ctlOe_q;
  assign bus.hostAdO = adO_q;
  assign bus.hostAdOe = adOe_q;
  assign bus.hostCbeO = cbeO_q;
  assign bus.hostCbeOe = cbeOe_q;
  assign bus.hostParO = parO_q;
  assign bus.hostParOe = parOe_q;
  assign bus.idsel = idsel_q;
  assign bus.busHoldGrantN = grantN_q;
  assign bus.hostSerrOe = serrOe_q;
  assign reqReady = reqReady_q;
  assign rspValid = rspValid_q;
  assign rspStatus = rspStatus_q;
  assign rspData = rspData_q;
endmodule // pbs_host_end

// ==== verification/pbs_bus_assertions.sv ====
`timescale 1ns/1ps
module pbs_bus_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Device end drive
  input wire logic devAdOe,
  input wire logic devCbeOe,
  input wire logic devParOe,
  input wire logic [4:0] devCtlO,
  input wire logic [4:0] devCtlOe,
  input wire logic busHoldRequestN,
  // Host end drive and resolved wires
  input wire logic [4:0] hostCtlOe,
  input wire logic busHoldGrantN,
  input wire logic idsel,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbeN,
  input wire logic par,
  input wire logic [4:0] ctlN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Host address phase, then a hit in the device IO or memory window
  sequence hostAddr;
    hostCtlOe[0] && $fell(ctlN[0]);
  endsequence
  sequence devHit;
    hostAddr ##0 (((ad & pbs_pkg::DEV_MASK) == pbs_pkg::DEV_BASE) && !cbeN[3] && cbeN[1]);
  endsequence
  // Device address phase as initiator
  sequence devAddr;
    devCtlOe[0] && !devCtlO[0];
  endsequence
  AST_PAR_EVEN: assert property (devParOe |-> par == ^{$past(ad), $past(cbeN)})
    else $error("parity not even");
  AST_ADDR_CMD: assert property (devAddr |-> (devAdOe && devCbeOe) ##1 (!devCtlO[1] && devCtlO[0]))
    else $error("address phase malformed");
  AST_RELEASE_HIGH: assert property ($fell(devCtlOe[1]) |-> $past(devCtlO[1]))
    else $error("ready released while low");
  AST_IDLE_GAP: assert property ($rose(devCtlOe[0]) |-> !(|$past(hostCtlOe)))
    else $error("frame driven without idle gap");
  AST_GRANT_START: assert property ($rose(devCtlOe[0]) |->
    !$past(busHoldGrantN) && !$past(busHoldRequestN))
    else $error("start without grant");
  // The arbiter only grants a request it has already sampled
  AST_GRANT_AFTER_REQ: assert property (!busHoldGrantN |-> !$past(busHoldRequestN))
    else $error("grant without request");
  AST_CLAIM_POS: assert property (devHit |=> !ctlN[4] && !ctlN[2])
    else $error("window hit not claimed");
  AST_CFG_SELECT: assert property (hostAddr ##0 (cbeN[3:1] == 3'h5) |=>
    (devCtlOe[4] && !devCtlO[4]) == $past(idsel))
    else $error("config claim disagrees with select");
  AST_TRDY_CLAIMED: assert property (devCtlOe[2] && !devCtlO[2] |-> !ctlN[4])
    else $error("ready without claim");
endmodule // pbs_bus_assertions

// ==== verification/pci_bus_side_interface_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin nTests++; if ((got) !== (ex)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module pci_bus_side_interface_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic subEn = 1'b0, nmiEn = 1'b0, nmiClr = 1'b0, passRel = 1'b0, serrPulse = 1'b0;
  logic [1:0] rqV = 2'h0;
  logic [3:0] rqCmd [2] = '{4'h0, 4'h0};
  logic [3:0] rqBeN [2] = '{4'h0, 4'h0};
  logic [31:0] rqAddr [2] = '{32'h0, 32'h0};
  logic [31:0] rqData [2] = '{32'h0, 32'h0};
  wire [1:0] rdy, rsV;
  wire [1:0] rsSt [2];
  wire [31:0] rsData [2];
  wire nmi;
  int miscompares = 0, nTests = 0;
  // Free-running bus clock
  always #12.5 clk = ~clk;
  pbs_bus_if bus ();
  pbs_device_end pbs_device_end_i (.clk(clk), .rst(rst), .bus(bus.dev), .subtractiveEn(subEn), .serrNmiEn(nmiEn),
    .nmiClear(nmiClr), .nmi(nmi), .reqValid(rqV[0]), .reqCmd(rqCmd[0]), .reqAddr(rqAddr[0]), .reqData(rqData[0]),
    .reqBeN(rqBeN[0]), .passiveRelease(passRel), .reqReady(rdy[0]), .rspValid(rsV[0]), .rspStatus(rsSt[0]),
    .rspData(rsData[0]));
  pbs_host_end pbs_host_end_i (.clk(clk), .rst(rst), .bus(bus.host), .serrPulse(serrPulse), .reqValid(rqV[1]),
    .reqCmd(rqCmd[1]), .reqAddr(rqAddr[1]), .reqData(rqData[1]), .reqBeN(rqBeN[1]), .reqReady(rdy[1]),
    .rspValid(rsV[1]), .rspStatus(rsSt[1]), .rspData(rsData[1]));
  pbs_bus_assertions pbs_bus_assertions_i (.clk(clk), .rst(rst), .devAdOe(bus.devAdOe), .devCbeOe(bus.devCbeOe),
    .devParOe(bus.devParOe), .devCtlO(bus.devCtlO), .devCtlOe(bus.devCtlOe), .busHoldRequestN(bus.busHoldRequestN),
    .hostCtlOe(bus.hostCtlOe), .busHoldGrantN(bus.busHoldGrantN), .idsel(bus.idsel), .ad(bus.ad), .cbeN(bus.cbeN),
    .par(bus.par), .ctlN(bus.ctlN));
  // Verdict and end of run
  task automatic printVerdict();
    $display("Comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // A bounded wait that ran out counts as a mismatch and ends the run at once
  task automatic giveUp(input string nm);
    $display("ERROR %s expected done seen timeout", nm);
    miscompares++;
    printVerdict();
  endtask
  // One transfer from end e (0 device, 1 host); request held one edge only since it is taken while idle
  task automatic xfer(input int e, input logic [3:0] cmd, input logic [31:0] addr, input logic [31:0] data,
    input logic [3:0] beN);
    int i;
    for (i = 0; i < 50 && rdy[e] !== 1'b1; i++) @(negedge clk);
    if (rdy[e] !== 1'b1)
      giveUp("ready");
    @(posedge clk);
    rqV[e] <= 1'b1;
    rqCmd[e] <= cmd;
    rqAddr[e] <= addr;
    rqData[e] <= data;
    rqBeN[e] <= beN;
    @(posedge clk);
    rqV[e] <= 1'b0;
    for (i = 0; i < 300 && rsV[e] !== 1'b1; i++) @(negedge clk);
    if (rsV[e] !== 1'b1)
      giveUp("answer");
  endtask
  // System error pulse, then let the report settle
  task automatic pulseSerr();
    @(posedge clk) serrPulse <= 1'b1;
    @(posedge clk) serrPulse <= 1'b0;
    repeat (3) @(negedge clk);
  endtask
  // Main sequence
  initial
  begin
    int i;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    xfer(1, pbs_pkg::CMD_MEM_WR, 32'h0000_1004, 32'hA5A5_F00D, 4'h0);
    xfer(1, pbs_pkg::CMD_MEM_WR, 32'h0000_1004, 32'h1234_5678, 4'hC);
    xfer(1, pbs_pkg::CMD_MEM_RD, 32'h0000_1004, 32'h0, 4'h0);
    `CHK("merged word", 32'hA5A5_5678, rsData[1])
    xfer(1, pbs_pkg::CMD_CFG_RD, 32'h0, 32'h0, 4'h0);
    `CHK("identity", pbs_pkg::ID_WORD, rsData[1])
    xfer(1, pbs_pkg::CMD_IO_RD, 32'h0000_0300, 32'h0, 4'h0);
    `CHK("unclaimed", pbs_pkg::RSP_ABORT, rsSt[1])
    @(posedge clk) subEn <= 1'b1;
    xfer(1, pbs_pkg::CMD_IO_RD, 32'h0000_0300, 32'h0, 4'h0);
    `CHK("subtractive", pbs_pkg::RSP_OK, rsSt[1])
    @(posedge clk) subEn <= 1'b0;
    xfer(0, pbs_pkg::CMD_MEM_WR, pbs_pkg::HOST_BASE, 32'hC3C3_0F0F, 4'h0);
    xfer(0, pbs_pkg::CMD_MEM_RD, pbs_pkg::HOST_BASE, 32'h0, 4'h0);
    `CHK("device read", 32'hC3C3_0F0F, rsData[0])
    xfer(0, pbs_pkg::CMD_MEM_RD, 32'h0000_2000, 32'h0, 4'h0);
    `CHK("device abort", pbs_pkg::RSP_ABORT, rsSt[0])
    // Passive release while the device waits for the bus
    fork
      xfer(0, pbs_pkg::CMD_MEM_WR, pbs_pkg::HOST_BASE, 32'h5A5A_5A5A, 4'h0);
      begin
        for (i = 0; i < 50 && bus.busHoldRequestN !== 1'b0; i++) @(negedge clk);
        if (bus.busHoldRequestN !== 1'b0)
          giveUp("request");
        @(posedge clk) passRel <= 1'b1;
        @(posedge clk) passRel <= 1'b0;
        @(negedge clk) `CHK("release", 1'b1, bus.busHoldRequestN)
        @(negedge clk) `CHK("re-request", 1'b0, bus.busHoldRequestN)
      end
    join
    pulseSerr();
    `CHK("nmi masked", 1'b0, nmi)
    @(posedge clk) nmiEn <= 1'b1;
    pulseSerr();
    `CHK("nmi raised", 1'b1, nmi)
    @(posedge clk) nmiClr <= 1'b1;
    @(posedge clk) nmiClr <= 1'b0;
    @(negedge clk) `CHK("nmi cleared", 1'b0, nmi)
    printVerdict();
  end
endmodule // pci_bus_side_interface_tb
